// ===== hw/fwse_pkg.sv
/*
  Constants, types and register map of the flash status host controller.
  Assumes a 25 MHz system clock and a parallel NOR flash on the far side.
*/
`default_nettype none
package fwse_pkg;
  localparam int CLK_NS   = 40;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS  = 35;
  localparam int SYNC_CYC = 3;
  localparam int RD_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] RD_LAST = 4'(RD_CYC - 1);
  localparam logic [3:0] WP_LAST = 4'(WP_CYC - 1);

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam logic [11:0] ADR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADR_UNLOCK2 = 12'h2aa;
  localparam logic [7:0]  CMD_SR_READ  = 8'h70;
  localparam logic [7:0]  CMD_SR_CLEAR = 8'h71;
  localparam logic [7:0]  CMD_RESET    = 8'hf0;
  localparam logic [7:0]  CMD_UNLOCK1  = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;

  localparam int BIT_TOG1  = 6;
  localparam int BIT_TOUT  = 5;
  localparam int BIT_ABORT = 1;
  localparam int SR_VALID  = 7;
  localparam int SR_ERASE  = 5;
  localparam int SR_PROG   = 4;
  localparam int SR_WBA    = 3;
  localparam int SR_PROT   = 1;
  localparam logic [7:0] POLL_MASK = 8'hee;
  localparam logic [7:0] SR_MASK   = 8'hfe;

  localparam int STAT_BUSY = 0;
  localparam int STAT_CLS  = 1;
  localparam int STAT_REF  = 3;
  localparam int STAT_RDY  = 4;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000, OP_WRITE = 3'b001, OP_READ  = 3'b010,
    OP_POLL   = 3'b011, OP_SRRD  = 3'b100, OP_RESET = 3'b101,
    OP_SRCLR  = 3'b110, OP_ABRST = 3'b111
  } fwse_op_t;

  typedef enum logic [1:0] {
    CLS_NONE = 2'b00, CLS_BUSY = 2'b01, CLS_EMBED = 2'b10, CLS_ABORT = 2'b11
  } fwse_cls_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_WAIT = 2'b10
  } fwse_st_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00, E_SETUP = 2'b01, E_STROBE = 2'b10, E_HOLD = 2'b11
  } fwse_eng_t;

  typedef struct packed {
    logic        last;
    logic        we;
    logic        own;
    logic [11:0] addr;
    logic [7:0]  data;
  } fwse_step_t;
endpackage : fwse_pkg
`default_nettype wire

// ===== hw/fwse_pin_cycle.sv
/*
  One asynchronous flash bus cycle (read or write) on the parallel pins.
  Assumes req_i arrives only while the engine is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module fwse_pin_cycle #(
  parameter int AW = 22,
  parameter int DW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          req_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o,
  output logic               done_o,
  output logic      [AW-1:0] fl_addr_o,
  input  wire logic [DW-1:0] fl_dq_i,
  output logic      [DW-1:0] fl_dq_o,
  output logic               fl_dq_oe_o,
  output logic               fl_ce_n_o,
  output logic               fl_oe_n_o,
  output logic               fl_we_n_o
);
  import fwse_pkg::*;

  fwse_eng_t         st_reg, st_next;
  logic [3:0]        cnt_reg, cnt_next;
  logic              wel_reg, wel_next;
  logic [AW-1:0]     addr_next;
  logic [DW-1:0]     dq_next, rdata_next, dq_s1, dq_s2;
  logic              oe_next, cen_next, oen_next, wen_next, done_next;

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    wel_next   = wel_reg;
    addr_next  = fl_addr_o;
    dq_next    = fl_dq_o;
    oe_next    = fl_dq_oe_o;
    cen_next   = fl_ce_n_o;
    oen_next   = fl_oe_n_o;
    wen_next   = fl_we_n_o;
    rdata_next = rdata_o;
    done_next  = 1'b0;
    case (st_reg)
      E_IDLE: if (req_i) begin
        addr_next = addr_i;
        dq_next   = wdata_i;
        wel_next  = we_i;
        oe_next   = we_i;
        cen_next  = 1'b0;
        st_next   = E_SETUP;
      end
      E_SETUP: begin
        cnt_next = 4'h0;
        wen_next = ~wel_reg;
        oen_next = wel_reg;
        st_next  = E_STROBE;
      end
      E_STROBE: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == (wel_reg ? WP_LAST : RD_LAST)) begin
          wen_next = 1'b1;
          oen_next = 1'b1;
          if (!wel_reg) rdata_next = dq_s2;
          st_next = E_HOLD;
        end
      end
      E_HOLD: begin
        cen_next  = 1'b1;
        oe_next   = 1'b0;
        done_next = 1'b1;
        st_next   = E_IDLE;
      end
      default: st_next = E_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg     <= E_IDLE;
      cnt_reg    <= 4'h0;
      wel_reg    <= 1'b0;
      fl_addr_o  <= '0;
      fl_dq_o    <= '0;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o  <= 1'b1;
      fl_oe_n_o  <= 1'b1;
      fl_we_n_o  <= 1'b1;
      rdata_o    <= '0;
      done_o     <= 1'b0;
      dq_s1      <= '0;
      dq_s2      <= '0;
    end else if (ce_i) begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      wel_reg    <= wel_next;
      fl_addr_o  <= addr_next;
      fl_dq_o    <= dq_next;
      fl_dq_oe_o <= oe_next;
      fl_ce_n_o  <= cen_next;
      fl_oe_n_o  <= oen_next;
      fl_we_n_o  <= wen_next;
      rdata_o    <= rdata_next;
      done_o     <= done_next;
      dq_s1      <= fl_dq_i;
      dq_s2      <= dq_s1;
    end
  end
endmodule : fwse_pin_cycle
`default_nettype wire

// ===== hw/fwse_host.sv
/*
  Host controller for a parallel NOR flash: runs commands, polls status,
  classifies errors and issues the clearing sequences. Wishbone slave.
  Assumes one 25 MHz clock; flash pins are asynchronous to it.
*/
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fwse_host #(
  parameter int AW = 22,
  parameter int DW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  output logic      [AW-1:0] fl_addr_o,
  input  wire logic [DW-1:0] fl_dq_i,
  output logic      [DW-1:0] fl_dq_o,
  output logic               fl_dq_oe_o,
  output logic               fl_ce_n_o,
  output logic               fl_oe_n_o,
  output logic               fl_we_n_o,
  input  wire logic          ready_busy_n_i
);
  import fwse_pkg::*;

  if (AW < 12 || AW > 32 || DW < 8 || DW > 32) begin : g_bad_width
    $error("fwse_host: AW must be 12..32 and DW 8..32");
  end

  fwse_st_t      st_reg, st_next;
  fwse_op_t      op_reg, op_next;
  fwse_cls_t     cls_reg, cls_next;
  logic [1:0]    step_reg, step_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [DW-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [DW-1:0] rd0_reg, rd0_next, rd1_reg, rd1_next;
  logic          ref_reg, ref_next, req_reg, req_next;
  logic          ack_next, rb_s1, rb_s2, acc, go;
  logic [31:0]   dat_next, addr_wide, wdata_wide;
  fwse_step_t    s;
  logic          eng_done;
  logic [DW-1:0] eng_rdata, eng_wdata;
  logic [AW-1:0] eng_addr;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic op_ok(input fwse_op_t op, input fwse_cls_t c);
    logic ok;
    case (c)
      CLS_EMBED: ok = op inside {OP_READ, OP_POLL, OP_SRRD, OP_RESET,
                                 OP_SRCLR};
      CLS_ABORT: ok = op inside {OP_READ, OP_POLL, OP_SRRD, OP_ABRST,
                                 OP_SRCLR};
      default:   ok = (op != OP_NONE);
    endcase
    return ok;
  endfunction : op_ok

  function automatic fwse_step_t seq(input fwse_op_t op,
                                     input logic [1:0] step);
    fwse_step_t r;
    r = '0;
    r.addr = ADR_UNLOCK1;
    case (op)
      OP_WRITE: begin r.last = 1'b1; r.we = 1'b1; r.own = 1'b1; end
      OP_READ:  begin r.last = 1'b1; r.own = 1'b1; end
      OP_POLL:  begin r.last = (step == 2'd2); r.own = 1'b1; end
      OP_SRRD: begin
        r.last = (step == 2'd1);
        r.we   = (step == 2'd0);
        r.own  = (step == 2'd1);
        r.data = CMD_SR_READ;
      end
      OP_RESET: begin r.last = 1'b1; r.we = 1'b1; r.data = CMD_RESET; end
      OP_SRCLR: begin r.last = 1'b1; r.we = 1'b1; r.data = CMD_SR_CLEAR; end
      OP_ABRST: begin
        r.last = (step == 2'd2);
        r.we   = 1'b1;
        r.addr = (step == 2'd1) ? ADR_UNLOCK2 : ADR_UNLOCK1;
        r.data = (step == 2'd0) ? CMD_UNLOCK1 :
                 (step == 2'd1) ? CMD_UNLOCK2 : CMD_RESET;
      end
      default: r.last = 1'b1;
    endcase
    return r;
  endfunction : seq

  assign s          = seq(op_reg, step_reg);
  assign eng_addr   = s.own ? addr_reg : AW'(s.addr);
  assign eng_wdata  = s.own ? wdata_reg : DW'(s.data);
  assign addr_wide  = 32'(addr_reg);
  assign wdata_wide = 32'(wdata_reg);
  assign acc        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign go         = acc && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0];

  always_comb begin
    st_next    = st_reg;
    op_next    = op_reg;
    cls_next   = cls_reg;
    step_next  = step_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    rd0_next   = rd0_reg;
    rd1_next   = rd1_reg;
    ref_next   = ref_reg;
    req_next   = 1'b0;
    ack_next   = acc;
    dat_next   = wb_dat_o;
    if (acc && wb_we_i) begin
      if (wb_adr_i == REG_ADDR)
        addr_next = AW'(merge(addr_wide, wb_dat_i, wb_sel_i));
      if (wb_adr_i == REG_WDATA)
        wdata_next = DW'(merge(wdata_wide, wb_dat_i, wb_sel_i));
    end else if (acc) begin
      case (wb_adr_i)
        REG_CTRL:   dat_next = {29'h0, op_reg};
        REG_ADDR:   dat_next = addr_wide;
        REG_WDATA:  dat_next = wdata_wide;
        REG_RDATA:  dat_next = 32'(rdata_reg);
        REG_STATUS: dat_next = {27'h0, rb_s2, ref_reg, cls_reg,
                                st_reg != ST_IDLE};
        default:    dat_next = 32'h0;
      endcase
    end
    if (go) begin
      if (st_reg == ST_IDLE &&
          op_ok(fwse_op_t'(wb_dat_i[2:0]), cls_reg)) begin
        op_next   = fwse_op_t'(wb_dat_i[2:0]);
        step_next = 2'd0;
        ref_next  = 1'b0;
        st_next   = ST_ISSUE;
      end else begin
        ref_next = 1'b1;
      end
    end
    case (st_reg)
      ST_IDLE: ;
      ST_ISSUE: begin
        req_next = 1'b1;
        st_next  = ST_WAIT;
      end
      ST_WAIT: if (eng_done) begin
        if (op_reg == OP_READ) rdata_next = eng_rdata;
        if (op_reg == OP_POLL) begin
          if (step_reg == 2'd0) rd0_next = eng_rdata;
          if (step_reg == 2'd1) rd1_next = eng_rdata;
          if (step_reg == 2'd2) begin
            rdata_next = eng_rdata & DW'(POLL_MASK);
            if (rd0_reg[BIT_TOG1] == rd1_reg[BIT_TOG1] ||
                rd1_reg[BIT_TOG1] == eng_rdata[BIT_TOG1])
              cls_next = CLS_NONE;
            else if (eng_rdata[BIT_ABORT])
              cls_next = CLS_ABORT;
            else if (rd1_reg[BIT_TOUT] && eng_rdata[BIT_TOUT])
              cls_next = CLS_EMBED;
            else
              cls_next = CLS_BUSY;
          end
        end
        if (op_reg == OP_SRRD && step_reg == 2'd1) begin
          rdata_next = eng_rdata & DW'(SR_MASK);
          if (!eng_rdata[SR_VALID])
            cls_next = CLS_BUSY;
          else if (eng_rdata[SR_WBA])
            cls_next = CLS_ABORT;
          else if ((eng_rdata[SR_ERASE] || eng_rdata[SR_PROG]) &&
                   !eng_rdata[SR_PROT])
            cls_next = CLS_EMBED;
          else
            cls_next = CLS_NONE;
        end
        if (s.last) begin
          if (op_reg inside {OP_RESET, OP_SRCLR, OP_ABRST})
            cls_next = CLS_NONE;
          st_next = ST_IDLE;
        end else begin
          step_next = step_reg + 2'd1;
          st_next   = ST_ISSUE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg    <= ST_IDLE;
      op_reg    <= OP_NONE;
      cls_reg   <= CLS_NONE;
      step_reg  <= 2'd0;
      addr_reg  <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      rd0_reg   <= '0;
      rd1_reg   <= '0;
      ref_reg   <= 1'b0;
      req_reg   <= 1'b0;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0;
      rb_s1     <= 1'b1;
      rb_s2     <= 1'b1;
    end else if (ce_i) begin
      st_reg    <= st_next;
      op_reg    <= op_next;
      cls_reg   <= cls_next;
      step_reg  <= step_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rd0_reg   <= rd0_next;
      rd1_reg   <= rd1_next;
      ref_reg   <= ref_next;
      req_reg   <= req_next;
      wb_ack_o  <= ack_next;
      wb_dat_o  <= dat_next;
      rb_s1     <= ready_busy_n_i;
      rb_s2     <= rb_s1;
    end
  end

  fwse_pin_cycle #(.AW(AW), .DW(DW)) u_pin (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .req_i      (req_reg),
    .we_i       (s.we),
    .addr_i     (eng_addr),
    .wdata_i    (eng_wdata),
    .rdata_o    (eng_rdata),
    .done_o     (eng_done),
    .fl_addr_o  (fl_addr_o),
    .fl_dq_i    (fl_dq_i),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_o (fl_dq_oe_o),
    .fl_ce_n_o  (fl_ce_n_o),
    .fl_oe_n_o  (fl_oe_n_o),
    .fl_we_n_o  (fl_we_n_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  poll_addr_a: assert property (
    (ce_i && req_reg && op_reg == OP_POLL) |=> fl_addr_o == $past(addr_reg))
    else $error("poll issued at an address other than the given one");
  embed_gate_a: assert property (
    (ce_i && go && st_reg == ST_IDLE && cls_reg == CLS_EMBED
     && !(wb_dat_i[2:0] inside {OP_READ, OP_POLL, OP_SRRD, OP_RESET,
                                OP_SRCLR})) |=> ref_reg && st_reg == ST_IDLE)
    else $error("forbidden command taken during embedded error");
  abort_gate_a: assert property (
    (ce_i && go && st_reg == ST_IDLE && cls_reg == CLS_ABORT
     && wb_dat_i[2:0] inside {OP_WRITE, OP_RESET}) |=> ref_reg)
    else $error("forbidden command taken during buffer abort");
  abort_clear_a: assert property (
    (ce_i && st_reg == ST_WAIT && eng_done && op_reg == OP_ABRST
     && step_reg == 2'd2) |=> cls_reg == CLS_NONE && st_reg == ST_IDLE)
    else $error("abort reset sequence did not clear the abort");
  clear_done_a: assert property (
    (ce_i && st_reg == ST_WAIT && eng_done && op_reg == OP_SRCLR)
    |=> cls_reg == CLS_NONE)
    else $error("status clear did not clear the error class");
  mask_bits_a: assert property (
    (ce_i && st_reg == ST_WAIT && eng_done && op_reg == OP_POLL
     && step_reg == 2'd2) |=> !rdata_reg[4] && !rdata_reg[0])
    else $error("reserved poll bits not masked");
endmodule : fwse_host
`default_nettype wire

// ===== test/fwse_flash_model.sv
/*
  Behavioural flash device: status overlay, error classes, ready/busy.
  Assumes host strobes are sampled on the bench clock; bench injects states.
*/
`timescale 1ns/1ps
`default_nettype none
module fwse_flash_model #(
  parameter int         PROT_CYC = 500,
  parameter int         WIN_CYC  = 200,
  parameter logic [6:0] SUS_SECT = 7'h00
) (
  input  wire logic        clk_i,
  input  wire logic        inj_i,
  input  wire logic [2:0]  inj_kind_i,
  input  wire logic [21:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  output logic      [15:0] dq_o,
  output logic             rb_low_o
);
  // States: 0 ready, 1 busy, 2 embedded error, 3 buffer abort, 4 protect,
  // 5 erase window, 6 suspend program, 7 abort in suspend
  logic [2:0]  st_reg;
  logic        sus_hit;
  logic        ers_tmr;
  logic        abt;
  logic        prot_reg;
  logic        tog_reg;
  logic        srp_reg;
  logic        oe_q;
  logic        we_q;
  logic        valid;
  logic [1:0]  unl_reg;
  logic [15:0] cnt_reg;
  logic [15:0] last_reg;
  logic [15:0] rd_val;
  initial begin
    st_reg = 3'h0;
    {prot_reg, tog_reg, srp_reg, oe_q, we_q} = 5'h03;
    unl_reg = 2'h0;
    cnt_reg = 16'h0;
    last_reg = 16'h0;
  end
  assign abt     = (st_reg == 3'h3) || (st_reg == 3'h7);
  assign valid   = (st_reg == 3'h0) || (st_reg == 3'h2) || abt;
  assign sus_hit = (addr_i[21:15] == SUS_SECT);
  assign ers_tmr = (st_reg == 3'h2) || (st_reg == 3'h4) || (st_reg == 3'h7)
                   || (st_reg == 3'h5 && cnt_reg == 16'(WIN_CYC));
  always_comb begin
    if (srp_reg) begin
      rd_val = {8'h00, valid, 2'b00, (st_reg == 3'h2) || abt || prot_reg,
                abt, 1'b0, prot_reg, 1'b0};
    end else if (st_reg == 3'h0) begin
      rd_val = 16'h0042;
    end else begin
      rd_val = {8'h00, 1'b0, tog_reg && !(st_reg == 3'h6 && sus_hit),
                st_reg == 3'h2, 1'b0, ers_tmr,
                tog_reg && (st_reg != 3'h7 || sus_hit), abt, 1'b0};
    end
  end
  // Released bus shows the inverse of its last value
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd_val : ~last_reg;
  assign rb_low_o = (st_reg != 3'h0);
  always @(posedge clk_i) begin
    oe_q <= oe_n_i;
    we_q <= we_n_i;
    last_reg <= dq_o;
    if (!oe_q && oe_n_i) begin
      tog_reg <= ~tog_reg;
      srp_reg <= 1'b0;
    end
    if (!we_q && we_n_i) begin
      if (dq_i[7:0] == 8'h70) begin
        srp_reg <= 1'b1;
      end else if (st_reg != 3'h4) begin
        unl_reg <= (dq_i[7:0] == 8'haa) ? 2'h1 :
                   (dq_i[7:0] == 8'h55 && unl_reg == 2'h1) ? 2'h2 : 2'h0;
        if (dq_i[7:0] == 8'h71 || (dq_i[7:0] == 8'hf0 &&
            (st_reg == 3'h2 || unl_reg == 2'h2))) begin
          st_reg <= 3'h0;
          prot_reg <= 1'b0;
        end
      end
    end
    if (st_reg == 3'h4) begin
      cnt_reg <= cnt_reg + 16'h1;
      if (cnt_reg == 16'(PROT_CYC - 1)) begin
        st_reg <= 3'h0;
        prot_reg <= 1'b1;
      end
    end
    if (st_reg == 3'h5 && cnt_reg != 16'(WIN_CYC)) begin
      cnt_reg <= cnt_reg + 16'h1;
    end
    if (inj_i) begin
      st_reg <= inj_kind_i;
      cnt_reg <= 16'h0;
      prot_reg <= 1'b0;
    end
  end
endmodule : fwse_flash_model
`default_nettype wire

// ===== test/fwse_host_tb.sv
/*
  Self-checking bench for the flash status host controller.
  Assumes fwse_flash_model as the far side and a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fwse_host_tb;
  import fwse_pkg::*;
  localparam int PROT_CYC = 500;
  localparam int WIN_CYC  = 200;
  typedef struct packed {
    logic [2:0] kind;
    logic [2:0] op;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [7:0] rd;
  } fwse_row_t;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [21:0] fl_addr_o;
  logic [15:0] fl_dq_o;
  logic [15:0] dev_dq;
  logic [15:0] dq_bus;
  logic        fl_dq_oe_o;
  logic        fl_ce_n_o;
  logic        fl_oe_n_o;
  logic        fl_we_n_o;
  logic        rb_low;
  logic        rb_n;
  logic        inj_i;
  logic [2:0]  inj_kind_i;
  logic [31:0] q;
  int          num_errors;
  int          n_checks;
  int          cycles;
  fwse_row_t rows [11] = '{
    '{3'h0, 3'h3, 8'h10, 8'hff, 8'h42}, '{3'h1, 3'h3, 8'h02, 8'h22, 8'h00},
    '{3'h2, 3'h3, 8'h04, 8'h2a, 8'h28}, '{3'h3, 3'h3, 8'h06, 8'h22, 8'h02},
    '{3'h4, 3'h3, 8'h02, 8'h22, 8'h00}, '{3'h2, 3'h4, 8'h04, 8'hff, 8'h90},
    '{3'h3, 3'h4, 8'h06, 8'hff, 8'h98}, '{3'h4, 3'h4, 8'h02, 8'hff, 8'h00},
    '{3'h0, 3'h4, 8'h10, 8'hff, 8'h80}, '{3'h6, 3'h3, 8'h00, 8'h62, 8'h00},
    '{3'h7, 3'h3, 8'h06, 8'h2a, 8'h0a}};
  assign dq_bus = fl_dq_oe_o ? fl_dq_o : dev_dq;
  assign rb_n = rb_low ? 1'b0 : 1'b1;
  fwse_host fwse_host_i (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .fl_addr_o, .fl_dq_i(dq_bus), .fl_dq_o, .fl_dq_oe_o, .fl_ce_n_o,
    .fl_oe_n_o, .fl_we_n_o, .ready_busy_n_i(rb_n));
  fwse_flash_model #(.PROT_CYC(PROT_CYC), .WIN_CYC(WIN_CYC))
      fwse_flash_model_i (.clk_i,
    .inj_i, .inj_kind_i, .addr_i(fl_addr_o), .dq_i(dq_bus),
    .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o),
    .dq_o(dev_dq), .rb_low_o(rb_low));
  always #20 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wb_xfer(input logic we, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer
  task automatic run_op(input logic [2:0] op);
    logic [31:0] r;
    wb_xfer(1'b1, REG_CTRL, {29'h0, op}, r);
    do wb_xfer(1'b0, REG_STATUS, 32'h0, r); while (r[STAT_BUSY] === 1'b1);
  endtask : run_op
  task automatic expect_status(input logic [7:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, REG_STATUS, 32'h0, r);
    check(r, {24'h0, exp});
  endtask : expect_status
  task automatic inject(input logic [2:0] k);
    @(posedge clk_i);
    inj_i <= 1'b1;
    inj_kind_i <= k;
    @(posedge clk_i);
    inj_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : inject
  task automatic wrap_up();
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, inj_i} = 5'h0;
    {wb_adr_i, wb_dat_i, inj_kind_i} = 43'h0;
    wb_sel_i = 4'hf;
    rst_i = 1'b1;
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk_i);
    check({31'h0, wb_ack_o}, 32'h0);
    check({31'h0, fl_ce_n_o}, 32'h1);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    expect_status(8'h10);
    wb_xfer(1'b1, 8'h20, 32'hffff_ffff, q);
    wb_xfer(1'b0, 8'h20, 32'h0, q);
    check(q, 32'h0);
    wb_xfer(1'b1, REG_ADDR, 32'h0000_0100, q);
    foreach (rows[i]) begin
      inject(rows[i].kind);
      run_op(rows[i].op);
      expect_status(rows[i].stat);
      wb_xfer(1'b0, REG_RDATA, 32'h0, q);
      q = q & {24'h0, rows[i].mask};
      check(q, {24'h0, rows[i].rd});
    end
    inject(3'h2);
    run_op(3'h3);
    run_op(3'h1);
    expect_status(8'h0c);
    run_op(3'h5);
    run_op(3'h3);
    expect_status(8'h10);
    inject(3'h3);
    run_op(3'h3);
    run_op(3'h5);
    expect_status(8'h0e);
    run_op(3'h4);
    run_op(3'h3);
    expect_status(8'h06);
    run_op(3'h7);
    run_op(3'h3);
    expect_status(8'h10);
    inject(3'h2);
    run_op(3'h3);
    run_op(3'h6);
    run_op(3'h3);
    expect_status(8'h10);
    inject(3'h4);
    run_op(3'h5);
    run_op(3'h3);
    expect_status(8'h02);
    repeat (PROT_CYC) @(posedge clk_i);
    run_op(3'h4);
    expect_status(8'h10);
    wb_xfer(1'b0, REG_RDATA, 32'h0, q);
    check(q, 32'h0000_0092);
    inject(3'h6);
    wb_xfer(1'b1, REG_ADDR, 32'h0000_8100, q);
    run_op(3'h3);
    expect_status(8'h02);
    inject(3'h5);
    run_op(3'h3);
    wb_xfer(1'b0, REG_RDATA, 32'h0, q);
    check(q & 32'h08, 32'h00);
    repeat (WIN_CYC) @(posedge clk_i);
    run_op(3'h3);
    wb_xfer(1'b0, REG_RDATA, 32'h0, q);
    check(q & 32'h08, 32'h08);
    inject(3'h2);
    run_op(3'h3);
    inject(3'h0);
    expect_status(8'h14);
    run_op(3'h1);
    expect_status(8'h1c);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    expect_status(8'h10);
    wrap_up();
  end
endmodule : fwse_host_tb
`default_nettype wire
